// [pkg/ew_pkg.sv]
/*
 * Shared constants and types for the three-wire serial EEPROM command
 * port: instruction encodings, array shape and timing counts.
 * Assumes a 10 MHz system clock at both ends of the link.
 */
// Overview of operation
// - Frame: start bit one, opcode, six-bit address.
// - Enable is opcode 00, address 11XXXX.
// - Read 10, erase 11, write 01.
// - Array is 64 words of 16 bits.
// - Bulk erase is opcode 00, address 10XXXX.
// - Bulk write is 00, 01XXXX, then data.
// - Disable is 00, 00XXXX; blocks programming.
// - Read data changes on shift clock rises.
// - One zero dummy bit precedes read data.
// - Power-up leaves programming disabled.
// - Host enables before any erase or write.
// - Enable holds until disable or power loss.
// - Erase sets word to ones, starts at decode.
// - Write cycle starts after sixteenth data bit.
// - Chip select low, high again shows status.
// - Status zero while busy, one when done.
// - No status if cycle ended before select.
// - Bulk erase sets all ones, same status.
// - Bulk write fills every word with data.
// - Read works enabled or disabled.
// - Host should disable after programming.
// - Enable, disable, bulk erase need nine clocks.
package ew_pkg;
   // ==========================================================
   // Array shape and instruction encoding
   localparam int EW_ADDR_W = 6;
   localparam int EW_DATA_W = 16;
   localparam int EW_WORDS = 64;
   localparam int EW_SYNC_N = 3;
   localparam int EW_FIFO_DEPTH = 8;
   localparam logic [1:0] EW_OP_EXT = 2'h0;
   localparam logic [1:0] EW_OP_WRITE = 2'h1;
   localparam logic [1:0] EW_OP_READ = 2'h2;
   localparam logic [1:0] EW_OP_ERASE = 2'h3;
   localparam logic [1:0] EW_EXT_DIS = 2'h0;
   localparam logic [1:0] EW_EXT_BWR = 2'h1;
   localparam logic [1:0] EW_EXT_BER = 2'h2;
   localparam logic [1:0] EW_EXT_EN = 2'h3;
   localparam logic [3:0] EW_EXT_PAD = 4'h0;
   localparam logic [4:0] EW_HDR_LAST = 5'h07;
   localparam logic [4:0] EW_DATA_LAST = 5'h0F;
   localparam logic [4:0] EW_DATA_BITS = 5'h10;
   localparam logic [4:0] EW_SHORT_CLKS = 5'h09;
   localparam logic [4:0] EW_LONG_CLKS = 5'h19;
   localparam int EW_FRAME_W = 25;
   // ==========================================================
   // Timing
   localparam int EW_CLK_NS = 100;
   localparam int EW_T_PROG_NS = 3000000;
   localparam int EW_T_PROG_CYC = (EW_T_PROG_NS + EW_CLK_NS - 1) / EW_CLK_NS;
   localparam int EW_T_CS_LOW_NS = 250;
   localparam int EW_T_CS_LOW_CYC =
      (EW_T_CS_LOW_NS + EW_CLK_NS - 1) / EW_CLK_NS;
   localparam int EW_T_SCLK_HALF_NS = 600;
   localparam int EW_T_SCLK_HALF_CYC =
      (EW_T_SCLK_HALF_NS + EW_CLK_NS - 1) / EW_CLK_NS;
   // ==========================================================
   // Host command set
   typedef enum logic [2:0] {
      EW_CMD_READ,
      EW_CMD_WRITE,
      EW_CMD_ERASE,
      EW_CMD_EN,
      EW_CMD_DIS,
      EW_CMD_BULK_ERASE,
      EW_CMD_BULK_WRITE
   } ew_cmd_type;
endpackage : ew_pkg

// [pkg/ew_link_if.sv]
/*
 * Three-wire link between the host end and the device end.
 * Assumes the serial output wire has a pull-up, so a released wire
 * reads as one.
 */
interface ew_link_if;
   logic chip_sel;
   logic shift_clock;
   logic serial_in;
   logic sout;
   logic sout_oe_n;
   logic sout_line;

   // ==========================================================
   // Wire resolution with pull-up
   assign sout_line = sout_oe_n ? 1'h1 : sout;

   modport dev (
      input chip_sel,
      input shift_clock,
      input serial_in,
      output sout,
      output sout_oe_n
   );
   modport host (
      output chip_sel,
      output shift_clock,
      output serial_in,
      input sout_line
   );
endinterface : ew_link_if

// [verilog/ew_dev.sv]
/*
 * Device end: instruction decoder, 64 x 16 word array and self-timed
 * program cycle of the serial EEPROM.
 * Assumes all link pins are asynchronous to clk_sys_i and that the
 * shift clock half period spans at least four system clocks.
 */
module ew_dev #(
   parameter int PROG_CYCLES = ew_pkg::EW_T_PROG_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   ew_link_if.dev link,
   output logic prog_enabled_o,
   output logic busy_o
);
   import ew_pkg::*;

   localparam int TW = $clog2(PROG_CYCLES + 1);

   if (PROG_CYCLES < 1) begin : g_chk
      $error("PROG_CYCLES must be at least one");
   end

   typedef enum logic [2:0] {
      D_IDLE,
      D_START,
      D_HDR,
      D_RDATA,
      D_WDATA,
      D_DONE
   } ew_dev_state_type;

   typedef struct packed {
      logic [EW_SYNC_N-1:0] cs_s;
      logic [EW_SYNC_N-1:0] sclk_s;
      logic [EW_SYNC_N-1:0] sin_s;
      logic cs_f;
      logic sclk_f;
      logic sin_f;
      logic cs_p;
      logic sclk_p;
      ew_dev_state_type st;
      logic [4:0] cnt;
      logic [7:0] hdr;
      logic [EW_DATA_W-1:0] dsh;
      logic en;
      logic busy;
      logic arm;
      logic status;
      logic [TW-1:0] tmr;
      logic dout;
      logic oe_n;
      logic [EW_WORDS-1:0][EW_DATA_W-1:0] mem;
   } ew_dev_st_type;

   ew_dev_st_type q;
   ew_dev_st_type d;
   logic sclk_rise;
   logic cs_rise;
   logic [7:0] nh;
   logic [EW_DATA_W-1:0] nd;

   // ==========================================================
   // Edge detection on filtered pins
   assign sclk_rise = q.sclk_f & ~q.sclk_p;
   assign cs_rise = q.cs_f & ~q.cs_p;
   assign nh = {q.hdr[6:0], q.sin_f};
   assign nd = {q.dsh[EW_DATA_W-2:0], q.sin_f};

   // ==========================================================
   // Next state
   always_comb begin
      logic go;
      go = 1'h0;
      d = q;
      // The first stage of each synchroniser feeds only the second.
      d.cs_s = {q.cs_s[EW_SYNC_N-2:0], link.chip_sel};
      d.sclk_s = {q.sclk_s[EW_SYNC_N-2:0], link.shift_clock};
      d.sin_s = {q.sin_s[EW_SYNC_N-2:0], link.serial_in};
      if (q.cs_s[1] == q.cs_s[2]) begin
         d.cs_f = q.cs_s[2];
      end
      if (q.sclk_s[1] == q.sclk_s[2]) begin
         d.sclk_f = q.sclk_s[2];
      end
      if (q.sin_s[1] == q.sin_s[2]) begin
         d.sin_f = q.sin_s[2];
      end
      d.cs_p = q.cs_f;
      d.sclk_p = q.sclk_f;

      if (q.busy) begin
         if (q.tmr == '0) begin
            d.busy = 1'h0;
         end else begin
            d.tmr = q.tmr - TW'(1);
         end
      end

      // Status is offered only if the cycle is still running when chip
      // select returns high; a late return shows nothing.
      if (cs_rise) begin
         d.status = q.arm & q.busy;
         d.arm = 1'h0;
      end

      case (q.st)
         D_IDLE: begin
            if (q.cs_f) begin
               d.st = D_START;
            end
         end
         D_START: begin
            // Leading zeros are skipped; a one while busy is ignored.
            if (sclk_rise && q.sin_f && !q.busy) begin
               d.st = D_HDR;
               d.cnt = '0;
               d.hdr = '0;
               d.status = 1'h0;
            end
         end
         D_HDR: begin
            if (sclk_rise) begin
               d.hdr = nh;
               d.cnt = q.cnt + 5'h01;
               if (q.cnt == EW_HDR_LAST) begin
                  d.st = D_DONE;
                  d.cnt = '0;
                  case (nh[7:6])
                     EW_OP_READ: begin
                        // Reads ignore the protection state.
                        d.dsh = q.mem[nh[5:0]];
                        d.dout = 1'h0;
                        d.st = D_RDATA;
                     end
                     EW_OP_WRITE: begin
                        d.st = D_WDATA;
                     end
                     EW_OP_ERASE: begin
                        if (q.en) begin
                           d.mem[nh[5:0]] = '1;
                           go = 1'h1;
                        end
                     end
                     default: begin
                        case (nh[5:4])
                           EW_EXT_EN: d.en = 1'h1;
                           EW_EXT_DIS: d.en = 1'h0;
                           EW_EXT_BER: begin
                              if (q.en) begin
                                 d.mem = '1;
                                 go = 1'h1;
                              end
                           end
                           default: d.st = D_WDATA;
                        endcase
                     end
                  endcase
               end
            end
         end
         D_WDATA: begin
            if (sclk_rise) begin
               d.dsh = nd;
               d.cnt = q.cnt + 5'h01;
               if (q.cnt == EW_DATA_LAST) begin
                  d.st = D_DONE;
                  // Nothing is programmed unless enabled.
                  if (q.en) begin
                     if (q.hdr[7:6] == EW_OP_WRITE) begin
                        d.mem[q.hdr[5:0]] = nd;
                     end else begin
                        d.mem = {EW_WORDS{nd}};
                     end
                     go = 1'h1;
                  end
               end
            end
         end
         D_RDATA: begin
            // Stops after the last data bit; extra clocks are ignored.
            if (sclk_rise && q.cnt != EW_DATA_BITS) begin
               d.dout = q.dsh[EW_DATA_W-1];
               d.dsh = {q.dsh[EW_DATA_W-2:0], 1'h0};
               d.cnt = q.cnt + 5'h01;
            end
         end
         D_DONE: begin
            d.st = D_DONE;
         end
         default: begin
            d.st = D_IDLE;
         end
      endcase

      // The array is updated at the start of the cycle; the timer only
      // models how long the part stays busy.
      if (go) begin
         d.busy = 1'h1;
         d.tmr = TW'(PROG_CYCLES - 1);
         d.arm = 1'h1;
      end

      if (!q.cs_f) begin
         d.st = D_IDLE;
         d.status = 1'h0;
      end
      if (d.status) begin
         d.dout = ~d.busy;
      end
      // Released whenever chip select is low.
      d.oe_n = ~(d.cs_f & q.cs_f & ((d.st == D_RDATA) | d.status));
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q.cs_s <= '0;
         q.sclk_s <= '0;
         q.sin_s <= '0;
         q.cs_f <= 1'h0;
         q.sclk_f <= 1'h0;
         q.sin_f <= 1'h0;
         q.cs_p <= 1'h0;
         q.sclk_p <= 1'h0;
         q.st <= D_IDLE;
         q.cnt <= '0;
         q.hdr <= '0;
         q.dsh <= '0;
         q.en <= 1'h0;
         q.busy <= 1'h0;
         q.arm <= 1'h0;
         q.status <= 1'h0;
         q.tmr <= '0;
         q.dout <= 1'h0;
         q.oe_n <= 1'h1;
         q.mem <= '1;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign link.sout = q.dout;
   assign link.sout_oe_n = q.oe_n;
   assign prog_enabled_o = q.en;
   assign busy_o = q.busy;
endmodule : ew_dev

// [verilog/ew_host.sv]
/*
 * Host end of the three-wire link: turns user commands into serial
 * frames, polls ready status after programming and buffers read words
 * in a small FIFO. Holds the FIFO module and the host module.
 * Assumes the device answers a rise within one shift clock half period
 * and a chip select rise within two.
 */
module ew_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two, at least two");
   end

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } ew_fifo_st_type;

   ew_fifo_st_type q;
   ew_fifo_st_type d;
   logic full;
   logic empty;

   assign empty = q.wp == q.rp;
   assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
   assign in_ready_o = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (in_valid_i && !full) begin
         d.mem[q.wp[AW-1:0]] = in_data_i;
         d.wp = q.wp + (AW + 1)'(1);
      end
      if (out_ready_i && !empty) begin
         d.rp = q.rp + (AW + 1)'(1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : ew_fifo

module ew_host #(
   parameter int RD_DEPTH = ew_pkg::EW_FIFO_DEPTH,
   parameter int SCLK_HALF = ew_pkg::EW_T_SCLK_HALF_CYC,
   parameter int CS_LOW = ew_pkg::EW_T_CS_LOW_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   ew_link_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire ew_pkg::ew_cmd_type cmd_op_i,
   input wire logic [ew_pkg::EW_ADDR_W-1:0] cmd_addr_i,
   input wire logic [ew_pkg::EW_DATA_W-1:0] cmd_data_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [ew_pkg::EW_DATA_W-1:0] rd_data_o
);
   import ew_pkg::*;

   if (SCLK_HALF < 4 || SCLK_HALF > 127 || CS_LOW < 3 ||
      CS_LOW > 255) begin : g_chk
      $error("SCLK_HALF must be 4..127 and CS_LOW 3..255");
   end

   typedef enum logic [2:0] {
      H_IDLE,
      H_LO,
      H_HI,
      H_GAP,
      H_POLL
   } ew_host_state_type;

   typedef struct packed {
      logic [EW_SYNC_N-1:0] do_s;
      logic do_f;
      ew_host_state_type st;
      logic [EW_FRAME_W-1:0] frame;
      logic [4:0] nclk;
      logic [4:0] cnt;
      logic [7:0] tmr;
      logic [EW_DATA_W-1:0] rx;
      logic isrd;
      logic prog;
      logic cs;
      logic sclk;
      logic sin;
      logic push;
   } ew_host_st_type;

   ew_host_st_type q;
   ew_host_st_type d;
   logic fifo_ready;
   logic [1:0] op;
   logic [EW_ADDR_W-1:0] adr;
   logic [EW_FRAME_W-1:0] frame;

   // ==========================================================
   // Frame assembly
   always_comb begin
      op = EW_OP_EXT;
      adr = cmd_addr_i;
      case (cmd_op_i)
         EW_CMD_READ: op = EW_OP_READ;
         EW_CMD_WRITE: op = EW_OP_WRITE;
         EW_CMD_ERASE: op = EW_OP_ERASE;
         EW_CMD_EN: adr = {EW_EXT_EN, EW_EXT_PAD};
         EW_CMD_DIS: adr = {EW_EXT_DIS, EW_EXT_PAD};
         EW_CMD_BULK_ERASE: adr = {EW_EXT_BER, EW_EXT_PAD};
         default: adr = {EW_EXT_BWR, EW_EXT_PAD};
      endcase
      frame = {1'h1, op, adr, cmd_data_i};
   end

   // A new command waits until the read buffer has room.
   assign cmd_ready_o = (q.st == H_IDLE) & fifo_ready;

   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      d.push = 1'h0;
      d.do_s = {q.do_s[EW_SYNC_N-2:0], link.sout_line};
      if (q.do_s[1] == q.do_s[2]) begin
         d.do_f = q.do_s[2];
      end
      if (q.tmr != 8'h00) begin
         d.tmr = q.tmr - 8'h01;
      end
      case (q.st)
         H_IDLE: begin
            if (cmd_valid_i && cmd_ready_o) begin
               d.frame = frame;
               d.isrd = cmd_op_i == EW_CMD_READ;
               d.prog = !(cmd_op_i inside {EW_CMD_READ, EW_CMD_EN,
                  EW_CMD_DIS});
               // Reads clock past the dummy bit and all data.
               d.nclk = (cmd_op_i inside {EW_CMD_READ, EW_CMD_WRITE,
                  EW_CMD_BULK_WRITE}) ? EW_LONG_CLKS : EW_SHORT_CLKS;
               d.cnt = '0;
               d.cs = 1'h1;
               d.sin = 1'h1;
               d.tmr = 8'(SCLK_HALF - 1);
               d.st = H_LO;
            end
         end
         H_LO: begin
            if (q.tmr == 8'h00) begin
               // Each sample sees the bit of the previous rise.
               d.rx = {q.rx[EW_DATA_W-2:0], q.do_f};
               if (q.cnt == q.nclk) begin
                  d.push = q.isrd;
                  d.cs = 1'h0;
                  d.tmr = 8'(CS_LOW - 1);
                  d.st = H_GAP;
               end else begin
                  d.sclk = 1'h1;
                  d.cnt = q.cnt + 5'h01;
                  d.tmr = 8'(SCLK_HALF - 1);
                  d.st = H_HI;
               end
            end
         end
         H_HI: begin
            if (q.tmr == 8'h00) begin
               d.sclk = 1'h0;
               d.frame = {q.frame[EW_FRAME_W-2:0], 1'h0};
               d.sin = q.frame[EW_FRAME_W-2];
               d.tmr = 8'(SCLK_HALF - 1);
               d.st = H_LO;
            end
         end
         H_GAP: begin
            d.sin = 1'h0;
            if (q.tmr == 8'h00) begin
               if (q.prog) begin
                  d.prog = 1'h0;
                  d.cs = 1'h1;
                  // Status must pass the device's and our own
                  // synchroniser before the wire can be trusted.
                  d.tmr = 8'(2 * SCLK_HALF - 1);
                  d.st = H_POLL;
               end else begin
                  d.st = H_IDLE;
               end
            end
         end
         H_POLL: begin
            // A released wire reads one, so a missed status ends too.
            if (q.tmr == 8'h00 && q.do_f) begin
               d.cs = 1'h0;
               d.tmr = 8'(CS_LOW - 1);
               d.st = H_GAP;
            end
         end
         default: begin
            d.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q.do_s <= '0;
         q.do_f <= 1'h0;
         q.st <= H_IDLE;
         q.frame <= '0;
         q.nclk <= '0;
         q.cnt <= '0;
         q.tmr <= '0;
         q.rx <= '0;
         q.isrd <= 1'h0;
         q.prog <= 1'h0;
         q.cs <= 1'h0;
         q.sclk <= 1'h0;
         q.sin <= 1'h0;
         q.push <= 1'h0;
      end else begin
         q <= d;
      end
   end

   assign link.chip_sel = q.cs;
   assign link.shift_clock = q.sclk;
   assign link.serial_in = q.sin;

   // ==========================================================
   // Read word buffer
   ew_fifo #(
      .WIDTH(EW_DATA_W),
      .DEPTH(RD_DEPTH)
   ) u_rd_fifo (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .in_valid_i(q.push),
      .in_ready_o(fifo_ready),
      .in_data_i(q.rx),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o(rd_data_o)
   );
endmodule : ew_host

// [testbench/ew_link_sva.sv]
/*
 * Checker for the three-wire link between the host and device ends.
 * Assumes it sits beside the link interface in the bench and that
 * PROG_CYCLES matches the device instance.
 */
module ew_link_sva #(
   parameter int PROG_CYCLES = 50
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic chip_sel,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic sout,
   input wire logic sout_oe_n,
   input wire logic sout_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // Margin covers the synchroniser and the host poll filter.
   localparam int BUSY_MAX = PROG_CYCLES + 20;
   logic sclk_q;
   logic [4:0] rises_q;

   // ==========================================================
   // Shift clock rises in the current frame
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_q <= 1'h0;
         rises_q <= 5'h00;
      end else begin
         sclk_q <= shift_clock;
         if (!chip_sel) begin
            rises_q <= 5'h00;
         end else if (shift_clock && !sclk_q && rises_q != 5'h1F) begin
            rises_q <= rises_q + 5'h01;
         end
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   // ==========================================================
   // Link properties
   a_start_bit_one: assert property (
      $rose(shift_clock) && chip_sel && rises_q == 5'h00 |-> serial_in)
      else $error("first bit of a frame is not one");
   a_frame_length: assert property (
      $fell(chip_sel) |-> rises_q inside {5'h00, 5'h09, 5'h19})
      else $error("frame has a wrong number of clocks");
   a_din_stable: assert property (
      chip_sel && shift_clock && $past(shift_clock) |-> $stable(serial_in))
      else $error("serial in moved while shift clock high");
   a_quiet_header: assert property (
      chip_sel && rises_q inside {[5'h01:5'h08]} |-> sout_oe_n)
      else $error("serial out driven before decode");
   a_dummy_zero: assert property (
      $fell(sout_oe_n) |-> !sout)
      else $error("first driven bit is not zero");
   a_release_idle: assert property (
      !chip_sel [*7] |-> sout_oe_n)
      else $error("serial out still driven when deselected");
   a_status_stays: assert property (
      chip_sel && rises_q == 5'h00 && !sout_oe_n && sout
      |=> sout || sout_oe_n)
      else $error("ready status went back to busy");
   a_busy_bounded: assert property (
      chip_sel && rises_q == 5'h00 && !sout_oe_n && !sout
      |-> ##[1:BUSY_MAX] (sout || sout_oe_n))
      else $error("busy status lasted too long");
   a_sout_on_rise: assert property (
      !sout_oe_n && !$past(sout_oe_n) && !shift_clock && $changed(sout)
      |-> sout)
      else $error("serial out changed away from a rise");
   c_status: cover property (chip_sel && rises_q == 5'h00 && !sout_oe_n);
endmodule : ew_link_sva

// [testbench/three_wire_eeprom_command_port_test.sv]
/*
 * Self-checking bench: host and device ends joined by the link.
 * Assumes the package, interface and design files are compiled first.
 */
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
   errors++; $display("Error at %0t ns: got %h, expected %h", \
   $time, (got), (exp)); end end

module three_wire_eeprom_command_port_test import ew_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // Short program cycle keeps the run brief.
   localparam int PROG = 50;
   logic clk_sys_i = 1'h0;
   logic rstn_i = 1'h0;
   logic cmd_valid_i = 1'h0;
   logic cmd_ready_o;
   ew_cmd_type cmd_op_i = EW_CMD_READ;
   logic [EW_ADDR_W-1:0] cmd_addr_i = 6'h00;
   logic [EW_DATA_W-1:0] cmd_data_i = 16'h0000;
   logic rd_valid_o;
   logic rd_ready_i = 1'h0;
   logic [EW_DATA_W-1:0] rd_data_o;
   logic prog_enabled_o;
   logic busy_o;
   logic busy_seen = 1'h0;
   int errors = 0;
   int checked = 0;

   ew_link_if i_ew_link_if ();
   ew_host i_ew_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .link(i_ew_link_if), .cmd_valid_i(cmd_valid_i),
      .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
      .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
      .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
      .rd_data_o(rd_data_o));
   ew_dev #(.PROG_CYCLES(PROG)) i_ew_dev (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .link(i_ew_link_if),
      .prog_enabled_o(prog_enabled_o), .busy_o(busy_o));
   ew_link_sva #(.PROG_CYCLES(PROG)) i_ew_link_sva (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .chip_sel(i_ew_link_if.chip_sel),
      .shift_clock(i_ew_link_if.shift_clock),
      .serial_in(i_ew_link_if.serial_in), .sout(i_ew_link_if.sout),
      .sout_oe_n(i_ew_link_if.sout_oe_n),
      .sout_line(i_ew_link_if.sout_line));

   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      if (busy_o === 1'h1) busy_seen <= 1'h1;
   end

   // ==========================================================
   // Access tasks
   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic give_up();
      errors++;
      $display("Error at %0t ns: wait limit reached", $time);
      print_verdict();
   endtask : give_up

   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready_o !== 1'h1) begin
         @(negedge clk_sys_i);
         n++;
         if (n > 3000) give_up();
      end
   endtask : wait_ready

   task automatic send(input ew_cmd_type op, input logic [5:0] addr,
      input logic [15:0] data);
      @(negedge clk_sys_i);
      wait_ready();
      cmd_valid_i = 1'h1;
      cmd_op_i = op;
      cmd_addr_i = addr;
      cmd_data_i = data;
      @(negedge clk_sys_i);
      cmd_valid_i = 1'h0;
   endtask : send

   // Clears the busy flag first so each operation is judged alone.
   task automatic prog(input ew_cmd_type op, input logic [5:0] addr,
      input logic [15:0] data);
      busy_seen = 1'h0;
      send(op, addr, data);
      wait_ready();
   endtask : prog

   task automatic pop(input logic [15:0] exp);
      int n;
      n = 0;
      @(negedge clk_sys_i);
      while (rd_valid_o !== 1'h1) begin
         @(negedge clk_sys_i);
         n++;
         if (n > 3000) give_up();
      end
      `CHK(rd_data_o, exp)
      rd_ready_i = 1'h1;
      @(negedge clk_sys_i);
      rd_ready_i = 1'h0;
   endtask : pop

   task automatic read(input logic [5:0] addr, input logic [15:0] exp);
      send(EW_CMD_READ, addr, 16'h0000);
      pop(exp);
   endtask : read

   // ==========================================================
   // Test sequence
   initial begin
      repeat (8) @(negedge clk_sys_i);
      rstn_i = 1'h1;
      `CHK(prog_enabled_o, 1'h0)
      `CHK(i_ew_link_if.sout_line, 1'h1)
      read(6'h05, 16'hFFFF);
      prog(EW_CMD_WRITE, 6'h05, 16'h1234);
      `CHK(busy_seen, 1'h0)
      read(6'h05, 16'hFFFF);
      prog(EW_CMD_EN, 6'h00, 16'h0000);
      `CHK(prog_enabled_o, 1'h1)
      for (int i = 0; i < 8; i++) begin
         prog(EW_CMD_WRITE, 6'(i), 16'hA500 + 16'(i));
         `CHK(busy_seen, 1'h1)
      end
      prog(EW_CMD_WRITE, 6'h3F, 16'h5A3C);
      // Eight reads fill the buffer while nothing is popped.
      for (int i = 0; i < 8; i++) send(EW_CMD_READ, 6'(i), 16'h0000);
      repeat (400) @(negedge clk_sys_i);
      `CHK(cmd_ready_o, 1'h0)
      for (int i = 0; i < 8; i++) pop(16'hA500 + 16'(i));
      `CHK(rd_valid_o, 1'h0)
      read(6'h3F, 16'h5A3C);
      prog(EW_CMD_ERASE, 6'h00, 16'h0000);
      `CHK(busy_seen, 1'h1)
      read(6'h00, 16'hFFFF);
      read(6'h01, 16'hA501);
      prog(EW_CMD_BULK_WRITE, 6'h00, 16'h1357);
      `CHK(busy_seen, 1'h1)
      read(6'h00, 16'h1357);
      read(6'h3F, 16'h1357);
      `CHK(prog_enabled_o, 1'h1)
      prog(EW_CMD_BULK_ERASE, 6'h15, 16'h0000);
      `CHK(busy_seen, 1'h1)
      read(6'h20, 16'hFFFF);
      prog(EW_CMD_WRITE, 6'h09, 16'h0F0F);
      read(6'h09, 16'h0F0F);
      prog(EW_CMD_DIS, 6'h00, 16'h0000);
      `CHK(prog_enabled_o, 1'h0)
      prog(EW_CMD_WRITE, 6'h09, 16'hFFFF);
      `CHK(busy_seen, 1'h0)
      prog(EW_CMD_ERASE, 6'h09, 16'h0000);
      `CHK(busy_seen, 1'h0)
      read(6'h09, 16'h0F0F);
      print_verdict();
   end
endmodule : three_wire_eeprom_command_port_test
